/* File: flcs_consts.svh */
// Constants of the flash command sequencer: offsets, fields, codes, timing
`ifndef FLCS_CONSTS_SVH
`define FLCS_CONSTS_SVH
`define FLCS_OFF_CTRL0 8'h00
`define FLCS_OFF_CTRL1 8'h04
`define FLCS_OFF_CTRL4 8'h08
`define FLCS_C0_READY 0
`define FLCS_C0_RWEN 1
`define FLCS_C0_LOWUNL 2
`define FLCS_C0_PERR 6
`define FLCS_C0_EERR 7
`define FLCS_C1_EW1 1
`define FLCS_C1_USRUNL 6
`define FLCS_C4_SUSEN 0
`define FLCS_C4_SUSREQ 1
`define FLCS_C4_SUSST 6
`define FLCS_SR_READY 7
`define FLCS_SR_EERR 5
`define FLCS_SR_PERR 4
`define FLCS_CMD_READ_ARRAY 8'hff
`define FLCS_CMD_READ_STATUS 8'h70
`define FLCS_CMD_CLEAR_STATUS 8'h50
`define FLCS_CMD_PROGRAM 8'h40
`define FLCS_CMD_ERASE 8'h20
`define FLCS_CMD_CONFIRM 8'hd0
`define FLCS_ERASED 16'hffff
`define FLCS_BLK_DATA_A 3'h6
`define FLCS_BLK_LOW_LAST 3'h1
`define FLCS_RESP_OK 2'h0
`define FLCS_RESP_ERR 2'h2
`define FLCS_CLK_MHZ 50
`define FLCS_PROG_US 2
`define FLCS_ERASE_US 20
`define FLCS_PROG_CYCLES (`FLCS_PROG_US * `FLCS_CLK_MHZ)
`define FLCS_ERASE_CYCLES (`FLCS_ERASE_US * `FLCS_CLK_MHZ)
`endif

/* File: flcs_pkg.sv */
// Types shared by the flash command sequencer
package flcs_pkg;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } flcs_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } flcs_axi_rsp_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [6:0] addr;
      logic [15:0] wdata;
   } flcs_fb_req_t;

   typedef struct packed {
      logic ack;
      logic [15:0] rdata;
   } flcs_fb_rsp_t;

   typedef enum logic [1:0] {
      FLCS_IDLE,
      FLCS_PROG_DATA,
      FLCS_ERASE_CONF,
      FLCS_BUSY
   } flcs_seq_t;

   typedef struct packed {
      flcs_axi_rsp_t axi;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      flcs_fb_rsp_t fb;
      flcs_seq_t seq;
      logic rd_status;
      logic [5:0] tgt_addr;
      logic [15:0] tgt_data;
      logic go_prog;
      logic go_erase;
      logic rwen;
      logic lowunl;
      logic ew1;
      logic usrunl;
      logic arm_rwen;
      logic arm_lowunl;
      logic arm_ew1;
      logic arm_usrunl;
      logic perr;
      logic eerr;
      logic susen;
      logic susreq;
   } flcs_main_st_t;

   typedef struct packed {
      logic busy;
      logic erase;
      logic susp;
      logic [11:0] cnt;
      logic [5:0] addr;
      logic [15:0] data;
      logic done;
      logic fail;
   } flcs_arr_st_t;

endpackage : flcs_pkg

/* File: flcs_array.sv */
// Flash word array with timed automatic program and block erase
`include "flcs_consts.svh"
module flcs_array
   import flcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic abort,
   input wire logic start_prog,
   input wire logic start_erase,
   input wire logic [5:0] addr,
   input wire logic [15:0] wdata,
   input wire logic suspend,
   input wire logic [5:0] rd_addr,
   output logic [15:0] rd_data,
   output logic busy,
   output logic suspended,
   output logic done,
   output logic fail
);

   logic [15:0] mem [0:63];
   flcs_arr_st_t s;
   flcs_arr_st_t next_s;

   assign rd_data = mem[rd_addr];
   assign busy = s.busy;
   assign suspended = s.susp;
   assign done = s.done;
   assign fail = s.fail;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      if ((start_prog || start_erase) && !s.busy)
      begin
         next_s.busy = 1'b1;
         next_s.erase = start_erase;
         next_s.susp = 1'b0;
         next_s.fail = 1'b0;
         next_s.addr = addr;
         next_s.data = wdata;
         next_s.cnt = start_erase ? 12'(`FLCS_ERASE_CYCLES) : 12'(`FLCS_PROG_CYCLES);
      end
      else if (s.busy)
      begin
         next_s.susp = s.erase && suspend;
         if (!next_s.susp)
         begin
            if (s.cnt == 12'h001)
            begin
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
               next_s.fail = !s.erase && (mem[s.addr] != `FLCS_ERASED);
            end
            else
            begin
               next_s.cnt = s.cnt - 12'h001;
            end
         end
      end
      if (abort)
      begin
         next_s = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         for (int i = 0; i < 64; i++)
         begin
            mem[i] <= `FLCS_ERASED;
         end
      end
      else if (next_s.done)
      begin
         if (s.erase)
         begin
            for (int i = 0; i < 8; i++)
            begin
               mem[{s.addr[5:3], 3'(i)}] <= `FLCS_ERASED;
            end
         end
         else if (!next_s.fail)
         begin
            mem[s.addr] <= s.data;
         end
      end
   end

endmodule : flcs_array

/* File: flcs_sequencer.sv */
// Flash command decoder, status logic and control registers over AXI4-Lite
//
// Behaviour
// - 16-bit even accesses, command high byte ignored, except read-array in the program data cycle needs FF
// - Read-array code selects persistent array reads
// - Read-status code makes reads return status
// - Clear-status zeroes both error flags
// - Program code then data starts auto-program
// - Ready low while busy, high when done
// - Program error reported; protected blocks refused
// - Programmed word cannot be reprogrammed
// - RAM-resident mode reads status until read-array
// - Erase setup then confirm erases block
// - Suspend flag low erasing, high suspended
// - Erase error reported; protected blocks refused
// - Abort resets control registers and operation
// - Block protection by unlock bits
// - Error flags block program and erase
// - Sequence errors set both flags
// - Status bit positions and reset values
`include "flcs_consts.svh"
module flcs_sequencer
   import flcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic abort,
   input flcs_axi_req_t axi_req,
   output flcs_axi_rsp_t axi_rsp,
   input flcs_fb_req_t fb_req,
   output flcs_fb_rsp_t fb_rsp
);

   flcs_main_st_t s;
   flcs_main_st_t next_s;
   logic [15:0] arr_rdata;
   logic arr_busy;
   logic arr_susp;
   logic arr_done;
   logic arr_fail;
   logic ready;
   logic [7:0] status;
   logic [7:0] cmd;
   logic [5:0] waddr;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [7:0] wbyte;

   ////////////////////////////////////////////////////////////////////////
   // Block write protection
   function automatic logic flcs_blk_ok(input logic [2:0] blk, input logic low,
                                        input logic usr);
      logic ok;
      ok = usr;
      if (blk >= `FLCS_BLK_DATA_A)
      begin
         ok = 1'b1;
      end
      else if (blk <= `FLCS_BLK_LOW_LAST)
      begin
         ok = low && usr;
      end
      return ok;
   endfunction : flcs_blk_ok

   assign axi_rsp = s.axi;
   assign fb_rsp = s.fb;
   assign ready = (s.seq != FLCS_BUSY) && !arr_busy;
   always_comb
   begin
      status = 8'h00;
      status[`FLCS_SR_READY] = ready;
      status[`FLCS_SR_EERR] = s.eerr;
      status[`FLCS_SR_PERR] = s.perr;
   end
   assign cmd = fb_req.wdata[7:0];
   assign waddr = fb_req.addr[6:1];

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (axi_req.araddr)
         `FLCS_OFF_CTRL0:
         begin
            rd_word[`FLCS_C0_READY] = ready;
            rd_word[`FLCS_C0_RWEN] = s.rwen;
            rd_word[`FLCS_C0_LOWUNL] = s.lowunl;
            rd_word[`FLCS_C0_PERR] = s.perr;
            rd_word[`FLCS_C0_EERR] = s.eerr;
         end
         `FLCS_OFF_CTRL1:
         begin
            rd_word[`FLCS_C1_EW1] = s.ew1;
            rd_word[`FLCS_C1_USRUNL] = s.usrunl;
         end
         `FLCS_OFF_CTRL4:
         begin
            rd_word[`FLCS_C4_SUSEN] = s.susen;
            rd_word[`FLCS_C4_SUSREQ] = s.susreq;
            rd_word[`FLCS_C4_SUSST] = arr_susp;
         end
         default:
         begin
            rd_hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_s = s;
      next_s.fb.ack = 1'b0;
      next_s.go_prog = 1'b0;
      next_s.go_erase = 1'b0;
      wbyte = 8'h00;

      // Flash-side command and data cycles
      if (fb_req.valid)
      begin
         next_s.fb.ack = 1'b1;
         if (!fb_req.write)
         begin
            next_s.fb.rdata = s.rd_status ? {8'h00, status} : arr_rdata;
         end
         else if (s.rwen && s.seq != FLCS_BUSY)
         begin
            case (s.seq)
               FLCS_PROG_DATA:
               begin
                  if (cmd == `FLCS_CMD_READ_ARRAY && fb_req.wdata[15:8] == 8'hff)
                  begin
                     next_s.seq = FLCS_IDLE;
                     next_s.rd_status = 1'b0;
                  end
                  else if (!flcs_blk_ok(waddr[5:3], s.lowunl, s.usrunl))
                  begin
                     next_s.seq = FLCS_IDLE;
                     next_s.perr = 1'b1;
                     next_s.eerr = 1'b1;
                  end
                  else
                  begin
                     next_s.seq = FLCS_BUSY;
                     next_s.go_prog = 1'b1;
                     next_s.tgt_addr = waddr;
                     next_s.tgt_data = fb_req.wdata;
                     next_s.rd_status = s.ew1 ? s.rd_status : 1'b1;
                  end
               end
               FLCS_ERASE_CONF:
               begin
                  next_s.seq = FLCS_IDLE;
                  if (cmd == `FLCS_CMD_READ_ARRAY)
                  begin
                     next_s.rd_status = 1'b0;
                  end
                  else if (cmd != `FLCS_CMD_CONFIRM
                           || !flcs_blk_ok(waddr[5:3], s.lowunl, s.usrunl))
                  begin
                     next_s.perr = 1'b1;
                     next_s.eerr = 1'b1;
                  end
                  else
                  begin
                     next_s.seq = FLCS_BUSY;
                     next_s.go_erase = 1'b1;
                     next_s.tgt_addr = waddr;
                     next_s.rd_status = s.ew1 ? s.rd_status : 1'b1;
                  end
               end
               default:
               begin
                  case (cmd)
                     `FLCS_CMD_READ_ARRAY:
                     begin
                        next_s.rd_status = 1'b0;
                     end
                     `FLCS_CMD_READ_STATUS:
                     begin
                        next_s.rd_status = 1'b1;
                     end
                     `FLCS_CMD_CLEAR_STATUS:
                     begin
                        next_s.perr = 1'b0;
                        next_s.eerr = 1'b0;
                     end
                     `FLCS_CMD_PROGRAM:
                     begin
                        if (!s.perr && !s.eerr)
                        begin
                           next_s.seq = FLCS_PROG_DATA;
                        end
                     end
                     `FLCS_CMD_ERASE:
                     begin
                        if (!s.perr && !s.eerr)
                        begin
                           next_s.seq = FLCS_ERASE_CONF;
                        end
                     end
                     default:
                     begin
                        next_s.perr = 1'b1;
                        next_s.eerr = 1'b1;
                     end
                  endcase
               end
            endcase
         end
      end

      if (s.seq == FLCS_BUSY && arr_done)
      begin
         next_s.seq = FLCS_IDLE;
         next_s.susreq = 1'b0;
         next_s.perr = s.perr || (arr_fail && !s.go_erase && !s.eerr && !s.perr);
         next_s.eerr = s.eerr;
      end

      // AXI4-Lite write channels, taken in either order
      if (axi_req.awvalid && s.axi.awready)
      begin
         next_s.aw_got = 1'b1;
         next_s.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && s.axi.wready)
      begin
         next_s.w_got = 1'b1;
         next_s.w_data = axi_req.wdata;
         next_s.w_strb = axi_req.wstrb;
      end
      if (s.axi.bvalid && axi_req.bready)
      begin
         next_s.axi.bvalid = 1'b0;
      end
      if (next_s.aw_got && next_s.w_got && !s.axi.bvalid)
      begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.axi.bvalid = 1'b1;
         next_s.axi.bresp = `FLCS_RESP_OK;
         wbyte = next_s.w_data[7:0];
         next_s.arm_rwen = 1'b0;
         next_s.arm_lowunl = 1'b0;
         next_s.arm_ew1 = 1'b0;
         next_s.arm_usrunl = 1'b0;
         case (next_s.aw_addr)
            `FLCS_OFF_CTRL0:
            begin
               if (next_s.w_strb[0])
               begin
                  next_s.rwen = wbyte[`FLCS_C0_RWEN] && (s.rwen || s.arm_rwen);
                  next_s.arm_rwen = !wbyte[`FLCS_C0_RWEN];
                  next_s.lowunl = s.rwen && wbyte[`FLCS_C0_LOWUNL]
                                  && (s.lowunl || s.arm_lowunl);
                  next_s.arm_lowunl = !wbyte[`FLCS_C0_LOWUNL];
               end
            end
            `FLCS_OFF_CTRL1:
            begin
               if (next_s.w_strb[0] && s.rwen)
               begin
                  next_s.ew1 = wbyte[`FLCS_C1_EW1] && (s.ew1 || s.arm_ew1);
                  next_s.arm_ew1 = !wbyte[`FLCS_C1_EW1];
                  next_s.usrunl = wbyte[`FLCS_C1_USRUNL] && (s.usrunl || s.arm_usrunl);
                  next_s.arm_usrunl = !wbyte[`FLCS_C1_USRUNL];
               end
            end
            `FLCS_OFF_CTRL4:
            begin
               if (next_s.w_strb[0])
               begin
                  next_s.susen = wbyte[`FLCS_C4_SUSEN];
                  next_s.susreq = wbyte[`FLCS_C4_SUSREQ] && s.seq == FLCS_BUSY;
               end
            end
            default:
            begin
               next_s.axi.bresp = `FLCS_RESP_ERR;
            end
         endcase
         if (!next_s.rwen)
         begin
            next_s.lowunl = 1'b0;
            next_s.ew1 = 1'b0;
            next_s.usrunl = 1'b0;
         end
      end
      next_s.axi.awready = !next_s.aw_got && !next_s.axi.bvalid;
      next_s.axi.wready = !next_s.w_got && !next_s.axi.bvalid;

      // AXI4-Lite read channels
      if (s.axi.rvalid && axi_req.rready)
      begin
         next_s.axi.rvalid = 1'b0;
      end
      if (axi_req.arvalid && s.axi.arready)
      begin
         next_s.axi.rvalid = 1'b1;
         next_s.axi.rdata = rd_word;
         next_s.axi.rresp = rd_hit ? `FLCS_RESP_OK : `FLCS_RESP_ERR;
      end
      next_s.axi.arready = !next_s.axi.rvalid;

      if (abort)
      begin
         next_s.seq = FLCS_IDLE;
         next_s.rd_status = 1'b0;
         next_s.go_prog = 1'b0;
         next_s.go_erase = 1'b0;
         next_s.rwen = 1'b0;
         next_s.lowunl = 1'b0;
         next_s.ew1 = 1'b0;
         next_s.usrunl = 1'b0;
         next_s.arm_rwen = 1'b0;
         next_s.arm_lowunl = 1'b0;
         next_s.arm_ew1 = 1'b0;
         next_s.arm_usrunl = 1'b0;
         next_s.perr = 1'b0;
         next_s.eerr = 1'b0;
         next_s.susen = 1'b0;
         next_s.susreq = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s <= '0;
         s.axi.awready <= 1'b1;
         s.axi.wready <= 1'b1;
         s.axi.arready <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   flcs_array u_array (
      .clock(clock),
      .rst(rst),
      .abort(abort),
      .start_prog(s.go_prog),
      .start_erase(s.go_erase),
      .addr(s.tgt_addr),
      .wdata(s.tgt_data),
      .suspend(s.susen && s.susreq),
      .rd_addr(waddr),
      .rd_data(arr_rdata),
      .busy(arr_busy),
      .suspended(arr_susp),
      .done(arr_done),
      .fail(arr_fail)
   );

endmodule : flcs_sequencer

/* File: flcs_properties.sv */
// Port-level assertions for the flash command sequencer
`include "flcs_consts.svh"
module flcs_properties
   import flcs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic abort,
   input flcs_axi_req_t axi_req,
   input flcs_axi_rsp_t axi_rsp,
   input flcs_fb_req_t fb_req,
   input flcs_fb_rsp_t fb_rsp
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   AST_FB_ACK: assert property (fb_req.valid |=> fb_rsp.ack)
      else $error("flash access not acknowledged");
   AST_FB_ACK_SRC: assert property (fb_rsp.ack |-> $past(fb_req.valid))
      else $error("acknowledge without access");
   AST_B_AFTER: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |=> axi_rsp.bvalid) else $error("write response missing");
   AST_R_AFTER: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read response missing");
   AST_BV_ONE: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
      else $error("write response repeated");
   AST_RV_ONE: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read response repeated");
   AST_AW_HOLD: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("write taken while response pending");
   AST_AR_HOLD: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
      else $error("read taken while response pending");
   AST_RST: assert property ($fell(rst) |-> axi_rsp.awready && axi_rsp.arready
      && !axi_rsp.bvalid && !axi_rsp.rvalid && !fb_rsp.ack) else $error("bad reset state");
   AST_RESP: assert property (axi_rsp.bvalid |-> axi_rsp.bresp inside
      {`FLCS_RESP_OK, `FLCS_RESP_ERR}) else $error("bad write response code");
   AST_BAD_ADDR: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready && !(axi_req.awaddr inside {`FLCS_OFF_CTRL0, `FLCS_OFF_CTRL1,
      `FLCS_OFF_CTRL4}) |=> axi_rsp.bresp == `FLCS_RESP_ERR)
      else $error("unmapped write not refused");
   cover property (fb_req.valid && fb_req.write);
   cover property (axi_rsp.bvalid && axi_rsp.bresp == `FLCS_RESP_ERR);
   cover property (axi_rsp.rvalid && axi_rsp.rdata[`FLCS_C0_PERR]);
endmodule : flcs_properties
bind flcs_sequencer flcs_properties chk (.clock(clock), .rst(rst), .abort(abort),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .fb_req(fb_req), .fb_rsp(fb_rsp));

/* File: flcs_cpu_model.sv */
// Processor-side model issuing flash commands and reads
`include "flcs_consts.svh"
module flcs_cpu_model
   import flcs_pkg::*;
(
   input wire logic clock,
   output flcs_fb_req_t fb_req
);
   timeunit 1ns;
   timeprecision 1ns;
   initial fb_req = '0;
   task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
      @(posedge clock);
      fb_req <= '{1'b1, w, {a[6:1], 1'b0}, d};
      @(posedge clock);
      fb_req <= '{1'b0, ~w, ~a, ~d};
      @(posedge clock);
   endtask : acc
   task automatic cmd(input logic [6:0] a, input logic [7:0] c);
      acc(1'b1, a, {8'($urandom), c});
   endtask : cmd
   task automatic prog(input logic [6:0] a, input logic [15:0] d);
      cmd(a, `FLCS_CMD_PROGRAM);
      acc(1'b1, a, d);
   endtask : prog
   task automatic erase(input logic [2:0] b);
      cmd({b, 4'h0}, `FLCS_CMD_ERASE);
      cmd({b, 4'he}, `FLCS_CMD_CONFIRM);
   endtask : erase
   task automatic rd(input logic [6:0] a);
      acc(1'b0, a, 16'h0);
   endtask : rd
endmodule : flcs_cpu_model

/* File: test_flcs_sequencer.sv */
// Self-checking bench for the flash command sequencer
`include "flcs_consts.svh"
module test_flcs_sequencer
   import flcs_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic abort = 1'b0;
   flcs_axi_req_t areq = '0;
   flcs_axi_rsp_t arsp;
   flcs_fb_req_t freq;
   flcs_fb_rsp_t frsp;
   logic [33:0] eq[$];
   logic [33:0] mq[$];
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   logic quiet = 1'b0;
   logic lastrd = 1'b0;
   logic [15:0] d;
   logic [6:0] a;
   flcs_sequencer dut (.clock(clock), .rst(rst), .abort(abort), .axi_req(areq),
      .axi_rsp(arsp), .fb_req(freq), .fb_rsp(frsp));
   flcs_cpu_model cpu (.clock(clock), .fb_req(freq));
   initial
   begin
      forever #10 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic take(input logic [33:0] seen);
      logic [33:0] m;
      m = (mq.size() > 0) ? mq.pop_front() : '1;
      check(seen & m, (eq.size() > 0) ? eq.pop_front() : ~seen);
   endtask : take
   task automatic summarize();
      $display("Compared %0d, mismatched %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   always @(posedge clock)
   begin
      if (!quiet && arsp.rvalid && areq.rready)
         take({arsp.rresp, arsp.rdata});
      if (arsp.bvalid && areq.bready)
         take({arsp.bresp, 32'h0});
      if (frsp.ack && lastrd)
         take({18'h0, frsp.rdata});
      lastrd = freq.valid && !freq.write;
      cyc++;
      if (cyc > 10000)
      begin
         fails++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] r);
      eq.push_back({r, 32'h0});
      mq.push_back('1);
      @(posedge clock);
      areq.awvalid <= 1'b1;
      areq.awaddr <= ad;
      areq.wvalid <= 1'b1;
      areq.wdata <= v;
      areq.wstrb <= 4'hf;
      areq.bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arsp.awready)
            areq.awvalid <= 1'b0;
         if (arsp.wready)
            areq.wvalid <= 1'b0;
      end
      while (!arsp.bvalid);
      areq.bready <= 1'b0;
   endtask : wr
   task automatic axrd(input logic [7:0] ad, output logic [31:0] v);
      @(posedge clock);
      areq.arvalid <= 1'b1;
      areq.araddr <= ad;
      areq.rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arsp.arready)
            areq.arvalid <= 1'b0;
      end
      while (!arsp.rvalid);
      v = arsp.rdata;
      areq.rready <= 1'b0;
   endtask : axrd
   task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
      logic [31:0] v;
      eq.push_back({`FLCS_RESP_OK, e});
      mq.push_back('1);
      axrd(ad, v);
   endtask : rdc
   task automatic frd(input logic [6:0] ad, input logic [15:0] e, input logic [15:0] m);
      eq.push_back({18'h0, e});
      mq.push_back({18'h0, m});
      cpu.rd(ad);
   endtask : frd
   task automatic wait_ready();
      logic [31:0] v;
      quiet <= 1'b1;
      v = '0;
      while (!v[`FLCS_C0_READY])
         axrd(`FLCS_OFF_CTRL0, v);
      quiet <= 1'b0;
   endtask : wait_ready
   task automatic unlock(input logic [7:0] ad, input logic [31:0] v);
      wr(ad, 32'h0, `FLCS_RESP_OK);
      wr(ad, v, `FLCS_RESP_OK);
   endtask : unlock
   task automatic clr(input logic [6:0] ad);
      cpu.cmd(ad, `FLCS_CMD_CLEAR_STATUS);
   endtask : clr
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h0ddde701));
      // no retry, wait, stop or clock stop
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      rdc(`FLCS_OFF_CTRL0, 32'h1);
      rdc(`FLCS_OFF_CTRL4, 32'h0);
      wr(8'h0c, 32'h0, `FLCS_RESP_ERR);
      cpu.cmd(7'h20, `FLCS_CMD_READ_STATUS);
      frd(7'h20, `FLCS_ERASED, 16'hffff);
      unlock(`FLCS_OFF_CTRL0, 32'h2);
      unlock(`FLCS_OFF_CTRL1, 32'h40);
      rdc(`FLCS_OFF_CTRL0, 32'h3);
      d = 16'($urandom) & 16'hfffe;
      cpu.prog(7'h20, d);
      rdc(`FLCS_OFF_CTRL0, 32'h2);
      wait_ready();
      frd(7'h20, 16'h0080, 16'h00b0);
      cpu.cmd(7'h20, `FLCS_CMD_READ_ARRAY);
      frd(7'h20, d, 16'hffff);
      cpu.prog(7'h20, ~d);
      wait_ready();
      rdc(`FLCS_OFF_CTRL0, 32'h43);
      frd(7'h20, 16'h0090, 16'h00b0);
      cpu.prog(7'h22, 16'h1234);
      cpu.cmd(7'h22, `FLCS_CMD_READ_ARRAY);
      frd(7'h22, `FLCS_ERASED, 16'hffff);
      frd(7'h20, d, 16'hffff);
      clr(7'h22);
      rdc(`FLCS_OFF_CTRL0, 32'h3);
      // explicit status read in RAM-resident mode
      cpu.cmd(7'h22, `FLCS_CMD_READ_STATUS);
      frd(7'h22, 16'h0080, 16'h00b0);
      cpu.cmd(7'h40, 8'h99);
      rdc(`FLCS_OFF_CTRL0, 32'hc3);
      clr(7'h40);
      cpu.cmd(7'h40, `FLCS_CMD_ERASE);
      cpu.cmd(7'h4e, 8'h33);
      rdc(`FLCS_OFF_CTRL0, 32'hc3);
      clr(7'h40);
      cpu.cmd(7'h40, `FLCS_CMD_ERASE);
      cpu.cmd(7'h4e, `FLCS_CMD_READ_ARRAY);
      rdc(`FLCS_OFF_CTRL0, 32'h3);
      frd(7'h20, d, 16'hffff);
      cpu.prog(7'h00, 16'h0);
      rdc(`FLCS_OFF_CTRL0, 32'hc3);
      clr(7'h00);
      unlock(`FLCS_OFF_CTRL0, 32'h2);
      wr(`FLCS_OFF_CTRL0, 32'h6, `FLCS_RESP_OK);
      cpu.prog(7'h00, 16'h0);
      rdc(`FLCS_OFF_CTRL0, 32'hc7);
      clr(7'h00);
      d = 16'($urandom) & 16'hfffe;
      cpu.prog(7'h60, d);
      wait_ready();
      rdc(`FLCS_OFF_CTRL0, 32'h7);
      cpu.cmd(7'h60, `FLCS_CMD_READ_ARRAY);
      frd(7'h60, d, 16'hffff);
      unlock(`FLCS_OFF_CTRL1, 32'h40);
      cpu.erase(3'h2);
      rdc(`FLCS_OFF_CTRL4, 32'h0);
      wr(`FLCS_OFF_CTRL4, 32'h3, `FLCS_RESP_OK);
      rdc(`FLCS_OFF_CTRL4, 32'h43);
      wr(`FLCS_OFF_CTRL4, 32'h1, `FLCS_RESP_OK);
      rdc(`FLCS_OFF_CTRL0, 32'h6);
      wait_ready();
      cpu.cmd(7'h2e, `FLCS_CMD_READ_ARRAY);
      frd(7'h20, `FLCS_ERASED, 16'hffff);
      for (int k = 0; k < 4; k++)
      begin
         a = 7'h20 + 7'(2 * k);
         d = 16'($urandom);
         cpu.prog(a, d);
         wait_ready();
         cpu.cmd(a, `FLCS_CMD_READ_ARRAY);
         frd(a, d, 16'hffff);
      end
      unlock(`FLCS_OFF_CTRL1, 32'h42);
      d = 16'($urandom);
      cpu.prog(7'h38, d);
      wait_ready();
      frd(7'h38, d, 16'hffff);
      cpu.prog(7'h30, 16'h0);
      abort <= 1'b1;
      @(posedge clock);
      abort <= 1'b0;
      rdc(`FLCS_OFF_CTRL0, 32'h1);
      rdc(`FLCS_OFF_CTRL1, 32'h0);
      frd(7'h30, `FLCS_ERASED, 16'hffff);
      repeat (2) @(posedge clock);
      summarize();
   end
endmodule : test_flcs_sequencer
